/* pkg/iplr_pkg.sv */
// Constants and carrier types of the interrupt priority level registers
package iplr_pkg;

  // Special function addresses of the four level registers
  localparam logic [7:0] ADDR_PRIO_HIGH_A = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_LOW_A = 8'hB8;
  localparam logic [7:0] ADDR_PRIO_HIGH_B = 8'hF7;
  localparam logic [7:0] ADDR_PRIO_LOW_B = 8'hF8;

  // Implemented bits of each group; the rest are reserved
  localparam logic [7:0] MASK_GROUP_A = 8'h7F;
  localparam logic [7:0] MASK_GROUP_B = 8'h0F;

  // Reset values of the implemented bits
  localparam logic [7:0] RESET_GROUP_A = 8'h00;
  localparam logic [7:0] RESET_GROUP_B = 8'h00;

  // Value returned for reserved bits and unmapped addresses
  localparam logic [7:0] READ_FILL = 8'h00;

  // Bit positions in group A (both low and high register)
  localparam int unsigned BIT_EXT_INT0 = 0;
  localparam int unsigned BIT_TIMER0 = 1;
  localparam int unsigned BIT_EXT_INT1 = 2;
  localparam int unsigned BIT_TIMER1 = 3;
  localparam int unsigned BIT_SERIAL = 4;
  localparam int unsigned BIT_TIMER2 = 5;
  localparam int unsigned BIT_CAPTURE_UNIT = 6;

  // Bit positions in group B (both low and high register)
  localparam int unsigned BIT_BUS_CTRL = 0;
  localparam int unsigned BIT_CONVERTER = 1;
  localparam int unsigned BIT_TIMER_OVERRUN = 2;
  localparam int unsigned BIT_SERIAL_PERIPH = 3;

  // Source numbering: group A bits 0..6 are sources 0..6, group B bits 0..3 are 7..10
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned GROUP_A_SRC = 7;
  localparam int unsigned GROUP_B_SRC = 4;
  localparam int unsigned SRC_W = 4;

  // Bit address layout: upper five bits select the register, lower three the bit
  localparam int unsigned BIT_SEL_W = 3;

  typedef logic [1:0] iplr_level_t;

  // Arbitration result handed to the core
  typedef struct packed {
    logic valid;
    logic preempt;
    logic [SRC_W-1:0] source;
    iplr_level_t level;
  } iplr_grant_t;

endpackage : iplr_pkg

/* rtl/iplr_arbiter.sv */
// Combinational level arbiter over the eleven interrupt sources
`timescale 1ns/10ps
module iplr_arbiter
(
  input wire logic [iplr_pkg::NUM_SRC-1:0] levelLo,
  input wire logic [iplr_pkg::NUM_SRC-1:0] levelHi,
  input wire logic [iplr_pkg::NUM_SRC-1:0] intPending,
  input wire logic [iplr_pkg::NUM_SRC-1:0] intEnable,
  input wire logic globalIntGate,
  input wire logic handlerActive,
  input wire iplr_pkg::iplr_level_t handlerLevel,
  output iplr_pkg::iplr_grant_t grant
);

  logic [iplr_pkg::NUM_SRC-1:0] eligible;
  iplr_pkg::iplr_level_t srcLevel [iplr_pkg::NUM_SRC];

  // Per-source level and eligibility
  for (genvar i = 0; i < iplr_pkg::NUM_SRC; i++)
  begin : g_src
    assign srcLevel[i] = {levelHi[i], levelLo[i]}; // see R4
    assign eligible[i] = globalIntGate & intEnable[i] & intPending[i]; // see R10
  end

  // Highest level wins; a tie goes to the lower source number, as in a fixed poll
  always_comb
  begin
    logic found;
    logic [iplr_pkg::SRC_W-1:0] bestSrc;
    iplr_pkg::iplr_level_t bestLvl;
    found = 1'b0;
    bestSrc = '0;
    bestLvl = '0;
    for (int j = 0; j < iplr_pkg::NUM_SRC; j++)
    begin
      if (eligible[j] && (!found || srcLevel[j] > bestLvl)) // see R12
      begin
        found = 1'b1;
        bestSrc = j[iplr_pkg::SRC_W-1:0];
        bestLvl = srcLevel[j];
      end
    end
    // A running handler is only interrupted by a strictly higher level
    grant.valid = found && (!handlerActive || bestLvl > handlerLevel); // see R12
    grant.preempt = found && handlerActive && bestLvl > handlerLevel;
    grant.source = bestSrc;
    grant.level = bestLvl;
  end

endmodule : iplr_arbiter

/* rtl/iplr_prio_regs.sv */
// Interrupt priority level registers with byte and bit access and level arbitration
// Function
// R1 - Low group A holds seven sources, bits 6..0
// R2 - Low group B holds four sources, bits 3..0
// R3 - High group A mirrors low group A bits
// R4 - Level is high bit over low bit
// R5 - Reserved bits read undefined; here zero
// R6 - Software never writes ones to reserved bits
// R7 - Group A clears on reset; low A bit-addressable
// R8 - Low group B clears; bit set/clear supported
// R9 - Low B at F8h, low A at B8h
// R10 - Arbitrate only with global gate and enable
// R11 - High group B at F7h, bits 3..0
// R12 - Highest level wins, may preempt lower handler
// R13 - Written levels steer arbitration next cycle
`timescale 1ns/10ps
module iplr_prio_regs
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData_ff,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrEn,
  input wire logic bitWrVal,
  input wire logic bitRdEn,
  output logic bitRdData_ff,
  input wire logic globalIntGate,
  input wire logic [iplr_pkg::NUM_SRC-1:0] intEnable,
  input wire logic [iplr_pkg::NUM_SRC-1:0] intPending,
  input wire logic handlerActive,
  input wire iplr_pkg::iplr_level_t handlerLevel,
  output iplr_pkg::iplr_grant_t grant_ff
);

  logic [7:0] prioLowA_ff;
  logic [7:0] prioHighA_ff;
  logic [7:0] prioLowB_ff;
  logic [7:0] prioHighB_ff;
  logic [7:0] nxt_prioLowA;
  logic [7:0] nxt_prioHighA;
  logic [7:0] nxt_prioLowB;
  logic [7:0] nxt_prioHighB;
  logic [7:0] nxt_sfrRdData;
  logic nxt_bitRdData;
  iplr_pkg::iplr_grant_t nxt_grant;

  // Byte address decode
  // Unmapped addresses select nothing and read back the fill value
  wire selLowA = (sfrAddr == iplr_pkg::ADDR_PRIO_LOW_A); // see R9
  wire selLowB = (sfrAddr == iplr_pkg::ADDR_PRIO_LOW_B); // see R9
  wire selHighA = (sfrAddr == iplr_pkg::ADDR_PRIO_HIGH_A); // see R3
  wire selHighB = (sfrAddr == iplr_pkg::ADDR_PRIO_HIGH_B); // see R11

  // Bit address decode: only the two low registers sit on bit-addressable rows.
  // The upper five bits name the register row and the lower three the bit;
  // rows of the high registers are not decoded, so bit access to them is ignored.
  wire [4:0] bitRow = bitAddr[7:iplr_pkg::BIT_SEL_W];
  wire [2:0] bitSel = bitAddr[iplr_pkg::BIT_SEL_W-1:0];
  wire bitRowLowA = (bitRow == iplr_pkg::ADDR_PRIO_LOW_A[7:iplr_pkg::BIT_SEL_W]); // see R7
  wire bitRowLowB = (bitRow == iplr_pkg::ADDR_PRIO_LOW_B[7:iplr_pkg::BIT_SEL_W]); // see R8
  wire [7:0] bitOneHot = 8'h01 << bitSel;

  // Bit write forms: set or clear one bit, keep the others
  wire [7:0] bitMergeLowA = bitWrVal ? (prioLowA_ff | bitOneHot) : (prioLowA_ff & ~bitOneHot);
  wire [7:0] bitMergeLowB = bitWrVal ? (prioLowB_ff | bitOneHot) : (prioLowB_ff & ~bitOneHot);

  // Write strobes, one per register and access kind
  wire byteWrLowA = sfrWrEn && selLowA;
  wire byteWrLowB = sfrWrEn && selLowB;
  wire byteWrHighA = sfrWrEn && selHighA;
  wire byteWrHighB = sfrWrEn && selHighB;
  wire bitWrLowA = bitWrEn && bitRowLowA; // see R7
  wire bitWrLowB = bitWrEn && bitRowLowB; // see R8

  // Next register values; a byte write wins over a bit write in the same cycle.
  // Reserved bits are masked so a stray one can never reach the arbiter.
  assign nxt_prioLowA = byteWrLowA ? (sfrWrData & iplr_pkg::MASK_GROUP_A)
                      : bitWrLowA ? (bitMergeLowA & iplr_pkg::MASK_GROUP_A)
                      : prioLowA_ff; // see R1 see R7 see R6
  assign nxt_prioLowB = byteWrLowB ? (sfrWrData & iplr_pkg::MASK_GROUP_B)
                      : bitWrLowB ? (bitMergeLowB & iplr_pkg::MASK_GROUP_B)
                      : prioLowB_ff; // see R2 see R8 see R6
  assign nxt_prioHighA = byteWrHighA ? (sfrWrData & iplr_pkg::MASK_GROUP_A)
                       : prioHighA_ff; // see R3
  assign nxt_prioHighB = byteWrHighB ? (sfrWrData & iplr_pkg::MASK_GROUP_B)
                       : prioHighB_ff; // see R11

  // Read mux; reserved bits are already zero in the stored value.
  // Software may not rely on them, so zero is as good as any value
  // and keeps the read data free of unknowns.
  wire [7:0] rdMux = selLowA ? prioLowA_ff
                   : selLowB ? prioLowB_ff
                   : selHighA ? prioHighA_ff
                   : selHighB ? prioHighB_ff
                   : iplr_pkg::READ_FILL; // see R5
  assign nxt_sfrRdData = sfrRdEn ? rdMux : iplr_pkg::READ_FILL;

  // Bit read of the two bit-addressable rows
  wire bitRdMux = bitRowLowA ? prioLowA_ff[bitSel]
                : bitRowLowB ? prioLowB_ff[bitSel]
                : 1'b0;
  assign nxt_bitRdData = bitRdEn & bitRdMux;

  // Source vectors in arbitration order:
  //   0 external 0, 1 timer 0, 2 external 1, 3 timer 1,
  //   4 serial port, 5 timer 2, 6 capture unit,
  //   7 bus controller, 8 converter, 9 timer overrun, 10 serial peripheral.
  // The lower number wins a tie, so group A outranks group B at equal level.
  wire [iplr_pkg::NUM_SRC-1:0] levelLo = {prioLowB_ff[iplr_pkg::GROUP_B_SRC-1:0],
                                          prioLowA_ff[iplr_pkg::GROUP_A_SRC-1:0]};
  wire [iplr_pkg::NUM_SRC-1:0] levelHi = {prioHighB_ff[iplr_pkg::GROUP_B_SRC-1:0],
                                          prioHighA_ff[iplr_pkg::GROUP_A_SRC-1:0]};

  // Arbiter works from the stored bits, so a write is seen from the next cycle;
  // a write taken at one edge steers the grant flop at the following edge.
  iplr_arbiter u_arbiter
  (
    .levelLo(levelLo),
    .levelHi(levelHi),
    .intPending(intPending),
    .intEnable(intEnable),
    .globalIntGate(globalIntGate),
    .handlerActive(handlerActive),
    .handlerLevel(handlerLevel),
    .grant(nxt_grant)
  ); // see R13

  // Low group A; reset clears every implemented bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prioLowA_ff <= iplr_pkg::RESET_GROUP_A; // see R7
    end
    else
    begin
      prioLowA_ff <= nxt_prioLowA;
    end
  end

  // High group A
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prioHighA_ff <= iplr_pkg::RESET_GROUP_A; // see R7
    end
    else
    begin
      prioHighA_ff <= nxt_prioHighA;
    end
  end

  // Low group B
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prioLowB_ff <= iplr_pkg::RESET_GROUP_B; // see R8
    end
    else
    begin
      prioLowB_ff <= nxt_prioLowB;
    end
  end

  // High group B
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prioHighB_ff <= iplr_pkg::RESET_GROUP_B;
    end
    else
    begin
      prioHighB_ff <= nxt_prioHighB;
    end
  end

  // Byte read data; falls back to the fill value one cycle after a read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sfrRdData_ff <= iplr_pkg::READ_FILL;
    end
    else
    begin
      sfrRdData_ff <= nxt_sfrRdData;
    end
  end

  // Bit read data, same timing as the byte read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bitRdData_ff <= 1'b0;
    end
    else
    begin
      bitRdData_ff <= nxt_bitRdData;
    end
  end

  // Grant leaves a flip-flop so the core sees no decode glitches
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      grant_ff <= '0;
    end
    else
    begin
      grant_ff <= nxt_grant; // see R12 see R13
    end
  end

endmodule : iplr_prio_regs

/* bench/iplr_props.sv */
// Port checker for the priority level registers
`timescale 1ns/10ps
module iplr_props
(
  input wire logic clk, input wire logic sys_rst,
  input wire logic [7:0] sfrAddr, input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData, input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData_ff, input wire logic [7:0] bitAddr,
  input wire logic bitWrEn, input wire logic bitWrVal, input wire logic bitRdEn,
  input wire logic bitRdData_ff, input wire logic globalIntGate,
  input wire logic [iplr_pkg::NUM_SRC-1:0] intEnable,
  input wire logic [iplr_pkg::NUM_SRC-1:0] intPending,
  input wire logic handlerActive, input wire iplr_pkg::iplr_level_t handlerLevel,
  input wire iplr_pkg::iplr_grant_t grant_ff
);
  logic gate_ff;
  logic [iplr_pkg::NUM_SRC-1:0] elig_ff;
  logic hact_ff;
  iplr_pkg::iplr_level_t hlev_ff;
  logic bitOk;
  logic mapped;
  // Last cycle's arbitration inputs; no reset needed since grant is zero in reset
  always_ff @(posedge clk)
  begin
    gate_ff <= globalIntGate;
    elig_ff <= intEnable & intPending;
    hact_ff <= handlerActive;
    hlev_ff <= handlerLevel;
  end
  // Implemented bits of the two bit-addressable rows, and the four byte addresses
  assign bitOk = (bitAddr[7:3] == 5'h17 && bitAddr[2:0] != 3'h7) ||
    (bitAddr[7:3] == 5'h1F && !bitAddr[2]);
  assign mapped = sfrAddr inside {8'hB7, 8'hB8, 8'hF7, 8'hF8};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_rd_idle_zero: assert property (!sfrRdEn |=> sfrRdData_ff == 8'h00)
    else $error("read data not zero without read");
  chk_unmapped_read: assert property (sfrRdEn && !mapped |=> sfrRdData_ff == 8'h00)
    else $error("unmapped read not zero");
  chk_resv_group_a: assert property (sfrRdEn && sfrAddr[7:4] == 4'hB |=> !sfrRdData_ff[7])
    else $error("reserved bit 7 read as one");
  chk_resv_group_b: assert property (sfrRdEn && sfrAddr == 8'hF8 |=> sfrRdData_ff[7:4] == 4'h0)
    else $error("reserved low B bits read as one");
  chk_bit_readback: assert property (bitWrEn && bitOk && !sfrWrEn ##1 !bitWrEn && !sfrWrEn
    ##1 bitRdEn && $stable(bitAddr) && !bitWrEn && !sfrWrEn
    |=> bitRdData_ff == $past(bitWrVal, 3))
    else $error("bit readback differs from bit written");
  chk_gate_off: assert property (!globalIntGate |=> !grant_ff.valid)
    else $error("grant with gate off");
  chk_none_eligible: assert property ((intEnable & intPending) == '0 |=> !grant_ff.valid)
    else $error("grant with no eligible source");
  chk_grant_source: assert property (grant_ff.valid |-> gate_ff && elig_ff[grant_ff.source])
    else $error("granted source not eligible");
  chk_preempt_level: assert property (grant_ff.valid |-> grant_ff.preempt == hact_ff &&
    (!hact_ff || grant_ff.level > hlev_ff))
    else $error("grant does not outrank running handler");
  cov_grant: cover property (grant_ff.valid);
  cov_preempt: cover property (grant_ff.preempt);
  cov_bit_one: cover property (bitRdData_ff);
endmodule : iplr_props
bind iplr_prio_regs iplr_props chk (.clk, .sys_rst, .sfrAddr, .sfrWrEn, .sfrWrData,
  .sfrRdEn, .sfrRdData_ff, .bitAddr, .bitWrEn, .bitWrVal, .bitRdEn, .bitRdData_ff,
  .globalIntGate, .intEnable, .intPending, .handlerActive, .handlerLevel, .grant_ff);

/* bench/iplr_prio_regs_tb_top.sv */
// Testbench of the priority level registers
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module iplr_prio_regs_tb_top;
  logic clk = 1'b0, sys_rst = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, bitWrEn = 1'b0;
  logic bitWrVal = 1'b0, bitRdEn = 1'b0, bitRdData_ff, globalIntGate = 1'b0;
  logic handlerActive = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, sfrRdData_ff;
  logic [10:0] intEnable = 11'h000, intPending = 11'h000;
  iplr_pkg::iplr_level_t handlerLevel = 2'h0;
  iplr_pkg::iplr_grant_t grant_ff;
  int err_count = 0, cmp_count = 0;
  iplr_prio_regs dut (.clk, .sys_rst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn,
    .sfrRdData_ff, .bitAddr, .bitWrEn, .bitWrVal, .bitRdEn, .bitRdData_ff,
    .globalIntGate, .intEnable, .intPending, .handlerActive, .handlerLevel, .grant_ff);
  // 50 MHz core clock
  initial forever #10 clk = ~clk;
  // Bus tasks: strobe one cycle, read result looked at just after its edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); sfrAddr <= a; sfrWrData <= d; sfrWrEn <= 1'b1;
    @(posedge clk); sfrWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); sfrAddr <= a; sfrRdEn <= 1'b1;
    @(posedge clk); sfrRdEn <= 1'b0;
    #1 `CHK("byte read", e, sfrRdData_ff)
  endtask : rd
  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clk); bitAddr <= a; bitWrVal <= v; bitWrEn <= 1'b1;
    @(posedge clk); bitWrEn <= 1'b0;
  endtask : bwr
  task automatic brd(input logic [7:0] a, input logic e);
    @(posedge clk); bitAddr <= a; bitRdEn <= 1'b1;
    @(posedge clk); bitRdEn <= 1'b0;
    #1 `CHK("bit read", e, bitRdData_ff)
  endtask : brd
  // Arbitration inputs applied, grant looked at once it has settled
  task automatic arb(input logic [10:0] p, input logic [10:0] en, input logic ha,
    input logic [1:0] hl, input iplr_pkg::iplr_grant_t e);
    @(posedge clk); intPending <= p; intEnable <= en; handlerActive <= ha; handlerLevel <= hl;
    repeat (2) @(posedge clk);
    #1 `CHK("grant", e, grant_ff)
  endtask : arb
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'hB7, 8'h00); rd(8'hB8, 8'h00); rd(8'hF7, 8'h00); rd(8'hF8, 8'h00);
    // Only implemented bits are written, reserved ones stay zero
    wr(8'hB7, 8'h55); wr(8'hB8, 8'h2A); wr(8'hF7, 8'h05); wr(8'hF8, 8'h0A);
    wr(8'hA8, 8'h3C);
    rd(8'hB7, 8'h55); rd(8'hB8, 8'h2A); rd(8'hF7, 8'h05); rd(8'hF8, 8'h0A);
    rd(8'hA8, 8'h00);
    $display("test byte access done");
    bwr(8'hFA, 1'h1); brd(8'hFA, 1'h1); bwr(8'hF9, 1'h0); brd(8'hF9, 1'h0);
    bwr(8'hBE, 1'h1); bwr(8'hB6, 1'h0); brd(8'hBE, 1'h1);
    rd(8'hF8, 8'h0C); rd(8'hB8, 8'h6A); rd(8'hB7, 8'h55);
    $display("test bit access done");
    wr(8'hB7, 8'h10); wr(8'hB8, 8'h01); wr(8'hF7, 8'h08); wr(8'hF8, 8'h08);
    globalIntGate <= 1'b1;
    arb(11'h411, 11'h7FF, 1'h0, 2'h0, {1'h1, 1'h0, 4'hA, 2'h3});
    arb(11'h411, 11'h3FF, 1'h0, 2'h0, {1'h1, 1'h0, 4'h4, 2'h2});
    arb(11'h011, 11'h7FF, 1'h1, 2'h2, {1'h0, 1'h0, 4'h4, 2'h2});
    arb(11'h011, 11'h7FF, 1'h1, 2'h1, {1'h1, 1'h1, 4'h4, 2'h2});
    arb(11'h006, 11'h7FF, 1'h0, 2'h0, {1'h1, 1'h0, 4'h1, 2'h0});
    wr(8'hB8, 8'h05);
    arb(11'h006, 11'h7FF, 1'h0, 2'h0, {1'h1, 1'h0, 4'h2, 2'h1});
    @(posedge clk);
    globalIntGate <= 1'b0;
    arb(11'h006, 11'h7FF, 1'h0, 2'h0, 8'h00);
    $display("test arbitration done");
    tally_and_finish;
  end
endmodule : iplr_prio_regs_tb_top
